// ===== dvc_dma_defs.vh
// Register map, field positions and reset values of the copy and pattern channel
`ifndef DVC_DMA_DEFS_VH
`define DVC_DMA_DEFS_VH

`define DVC_ADDR_W        5
`define DVC_OFS_CTRL      5'h00
`define DVC_OFS_STATUS    5'h04
`define DVC_OFS_SRC       5'h08
`define DVC_OFS_DST       5'h0c
`define DVC_OFS_COUNT     5'h10
`define DVC_OFS_PATTERN   5'h14
`define DVC_OFS_BLKSIZE   5'h18
`define DVC_OFS_REMAIN    5'h1c

`define DVC_CTRL_GO       0
`define DVC_CTRL_PATMODE  1
`define DVC_CTRL_DSTPCI   2
`define DVC_CTRL_PAT32    3
`define DVC_CTRL_PATINC   4

`define DVC_STAT_BUSY     0
`define DVC_STAT_DONE     1
`define DVC_STAT_DRAIN    2

`define DVC_RST_CTRL      5'h00
`define DVC_RST_WORD      32'h0000_0000
`define DVC_RST_BLKSIZE   32'h0000_0020
`define DVC_RST_REM       33'h0_0000_0000

`define DVC_WAIT_CYCLES   1

`endif

// ===== dvc_dma.v
// Copy and pattern fill channel with its staging FIFO and bus slave
`include "dvc_dma_defs.vh"

module dvc_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             core_clk,
	input  wire             rstn,
	input  wire             inValid,
	output reg              inReady,
	input  wire [WIDTH-1:0] inData,
	output wire             outValid,
	input  wire             outReady,
	output wire [WIDTH-1:0] outData,
	output reg  [AW:0]      level
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wrPtr;
	reg  [AW-1:0]    rdPtr;
	wire             push;
	wire             pop;
	wire [AW:0]      next_level;

	assign push       = inValid & inReady;
	assign pop        = outValid & outReady;
	assign outValid   = (level != {(AW+1){1'b0}});
	assign outData    = mem[rdPtr];
	assign next_level = level + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	// Ready is registered so the source never sees a combinational path
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr   <= {AW{1'b0}};
			rdPtr   <= {AW{1'b0}};
			level   <= {(AW+1){1'b0}};
			inReady <= 1'b0;
		end else begin
			if (push)
				wrPtr <= wrPtr + 1'b1;
			if (pop)
				rdPtr <= rdPtr + 1'b1;
			level   <= next_level;
			inReady <= (next_level < DEPTH[AW:0]);
		end
	end

	always @(posedge core_clk) begin
		if (push)
			mem[wrPtr] <= inData;
	end
endmodule

// Function
// RULE1: Byte count from one byte to 4 GB, zero meaning 4 GB, moved exactly.
// RULE2: Software programs all settings first; go bit alone starts the channel.
// RULE3: Copy starts by raising a read request toward the linkage arbiter.
// RULE4: Granted read passes command, address, size to one of two read queues.
// RULE5: Queued read is a VMEbus read aimed at the programmed source slave.
// RULE6: Read data returns per block: whole read or programmed fetch block size. The code also caps each read at the room left in staging.
// RULE7: Returned read data lands in the staging FIFO between source and destination.
// RULE8: Staged data for the destination raises a write request to the arbiter.
// RULE9: Granted write passes command, address and data into write queues.
// RULE10: VME copy fills staging to a threshold, then drains; never both together.
// RULE11: Pattern fill goes to VME or PCI/X, any size, any start address.
// RULE12: The software start value is the first pattern written.
// RULE13: Option selects a static pattern or an incrementing one.
// RULE14: Option selects an 8-bit or a 32-bit pattern unit.
// RULE15: 32-bit patterns to PCI/X space are never byte swapped.
// RULE16: With 32-bit units a ragged count writes only part of the last one.
// RULE17: Trimmed bytes go from the top for PCI/X, the bottom for VME.
// RULE18: Incrementing adds one per pattern unit, wrapping inside the unit width.
// RULE19: Requests stop once the whole byte count has reached the destination.
module dvc_dma #(
	parameter FIFO_DEPTH  = 16,
	parameter FIFO_AW     = 4,
	parameter FILL_THRESH = 8
) (
	input  wire                   core_clk,
	input  wire                   rstn,
	input  wire [`DVC_ADDR_W-1:0] avAddress,
	input  wire                   avRead,
	input  wire                   avWrite,
	input  wire [3:0]             avByteenable,
	input  wire [31:0]            avWritedata,
	output reg  [31:0]            avReaddata,
	output reg                    avWaitrequest,
	output reg                    lnkRdReq,
	input  wire                   lnkRdGnt,
	output reg  [31:0]            lnkRdAddr,
	output reg  [31:0]            lnkRdSize,
	output reg                    lnkRdQueue,
	input  wire                   lnkRetValid,
	output wire                   lnkRetReady,
	input  wire [31:0]            lnkRetData,
	output reg                    lnkWrReq,
	input  wire                   lnkWrGnt,
	output reg  [31:0]            lnkWrAddr,
	output reg  [31:0]            lnkWrData,
	output reg  [2:0]             lnkWrSize,
	output reg                    lnkWrPci,
	output reg                    chanBusy
);
	reg  [4:0]         ctrl;
	reg                done;
	reg  [31:0]        srcAddr;
	reg  [31:0]        dstAddr;
	reg  [31:0]        byteCount;
	reg  [31:0]        patStart;
	reg  [31:0]        blkSize;
	reg  [32:0]        rdRem;
	reg  [32:0]        genRem;
	reg  [32:0]        wrRem;
	reg  [FIFO_AW:0]   rdOutW;
	reg  [31:0]        rdPtrAddr;
	reg  [31:0]        patCur;
	reg                drain;
	wire               patMode;
	wire               pat32;
	wire               dstPci;
	wire               busWr;
	wire               goPat;
	wire               goPci;
	wire               goHit;
	wire [3:0]         be;
	wire [31:0]        wmask;
	wire [FIFO_AW:0]   level;
	wire               fifoInReady;
	wire               fifoOutValid;
	wire [31:0]        fifoOutData;
	wire               genPush;
	wire               retPush;
	wire               fifoPop;
	wire [32:0]        rdRemW;
	wire [32:0]        blkW;
	wire [32:0]        freeW;
	wire [32:0]        reqW;
	wire [32:0]        reqB;
	wire [2:0]         wrUnit;
	wire [2:0]         genUnit;
	wire [31:0]        wrDataFmt;
	reg  [31:0]        next_readdata;

	assign patMode = ctrl[`DVC_CTRL_PATMODE];
	assign pat32   = ctrl[`DVC_CTRL_PAT32];
	assign dstPci  = ctrl[`DVC_CTRL_DSTPCI];
	// Writes take effect only on the edge that ends the low waitrequest cycle; read data is captured one edge earlier
	assign busWr   = avWrite & ~avWaitrequest;
	// Mode comes from the go write itself; ctrl only updates on that same edge
	assign goPat   = avWritedata[`DVC_CTRL_PATMODE];
	assign goPci   = avWritedata[`DVC_CTRL_DSTPCI];
	assign be      = avByteenable;
	assign wmask   = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	assign goHit   = busWr & (avAddress == `DVC_OFS_CTRL) & be[0]
		& avWritedata[`DVC_CTRL_GO] & ~chanBusy; // [RULE2]

	// Bus slave: one wait cycle, then the answer
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			avWaitrequest <= 1'b1;
		else if ((avRead | avWrite) & avWaitrequest)
			avWaitrequest <= 1'b0;
		else
			avWaitrequest <= 1'b1;
	end

	always @* begin
		next_readdata = 32'h0000_0000;
		case (avAddress)
			`DVC_OFS_CTRL:    next_readdata = {27'h0, ctrl[4:1], 1'b0};
			`DVC_OFS_STATUS:  next_readdata = {29'h0, drain, done, chanBusy};
			`DVC_OFS_SRC:     next_readdata = srcAddr;
			`DVC_OFS_DST:     next_readdata = dstAddr;
			`DVC_OFS_COUNT:   next_readdata = byteCount;
			`DVC_OFS_PATTERN: next_readdata = patStart;
			`DVC_OFS_BLKSIZE: next_readdata = blkSize;
			`DVC_OFS_REMAIN:  next_readdata = wrRem[31:0];
			default:          next_readdata = 32'h0000_0000;
		endcase
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			avReaddata <= `DVC_RST_WORD;
		else if (avRead & avWaitrequest)
			avReaddata <= next_readdata;
	end

	// Settings are frozen while the channel runs
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl      <= `DVC_RST_CTRL;
			srcAddr   <= `DVC_RST_WORD;
			dstAddr   <= `DVC_RST_WORD;
			byteCount <= `DVC_RST_WORD;
			patStart  <= `DVC_RST_WORD;
			blkSize   <= `DVC_RST_BLKSIZE;
		end else if (busWr & ~chanBusy) begin // [RULE2]
			case (avAddress)
				`DVC_OFS_CTRL:    if (be[0]) ctrl <= {avWritedata[4:1], 1'b0};
				`DVC_OFS_SRC:     srcAddr   <= (srcAddr & ~wmask) | (avWritedata & wmask);
				`DVC_OFS_DST:     dstAddr   <= (dstAddr & ~wmask) | (avWritedata & wmask);
				`DVC_OFS_COUNT:   byteCount <= (byteCount & ~wmask) | (avWritedata & wmask);
				`DVC_OFS_PATTERN: patStart  <= (patStart & ~wmask) | (avWritedata & wmask);
				`DVC_OFS_BLKSIZE: blkSize   <= (blkSize & ~wmask) | (avWritedata & wmask);
				default:          ctrl      <= ctrl;
			endcase
		end
	end

	// Read sizing: whole rest, one fetch block, or the room left in staging
	assign rdRemW = (rdRem + 33'd3) >> 2;
	assign blkW   = (blkSize[31:2] == 30'h0) ? 33'd1 : {3'b000, blkSize[31:2]};
	assign freeW  = {{(33-FIFO_AW-1){1'b0}}, FIFO_DEPTH[FIFO_AW:0] - level - rdOutW};
	assign reqW   = (rdRemW < blkW) ? ((rdRemW < freeW) ? rdRemW : freeW)
		: ((blkW < freeW) ? blkW : freeW); // [RULE6]
	assign reqB   = ((reqW << 2) < rdRem) ? (reqW << 2) : rdRem;

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lnkRdReq   <= 1'b0;
			lnkRdAddr  <= `DVC_RST_WORD;
			lnkRdSize  <= `DVC_RST_WORD;
			lnkRdQueue <= 1'b0;
			rdRem      <= `DVC_RST_REM;
			rdPtrAddr  <= `DVC_RST_WORD;
			rdOutW     <= {(FIFO_AW+1){1'b0}};
		end else begin
			if (goHit) begin
				rdRem     <= goPat ? 33'h0 : {(byteCount == 32'h0), byteCount}; // [RULE1]
				rdPtrAddr <= srcAddr; // [RULE5]
			end else if (lnkRdReq & lnkRdGnt) begin
				lnkRdReq   <= 1'b0;
				lnkRdQueue <= ~lnkRdQueue; // [RULE4]
				rdRem      <= rdRem - {1'b0, lnkRdSize};
				rdPtrAddr  <= rdPtrAddr + lnkRdSize;
			end else if (chanBusy & ~patMode & ~drain & ~lnkRdReq & ~lnkWrReq
				& (level < FILL_THRESH[FIFO_AW:0])
				& (rdRem != 33'h0) & (reqW != 33'h0)) begin
				// Met threshold or waiting write holds reads off
				lnkRdReq  <= 1'b1; // [RULE3]
				lnkRdAddr <= rdPtrAddr; // [RULE5]
				lnkRdSize <= reqB[31:0];
			end
			// Outstanding words reserve staging room until they return
			rdOutW <= rdOutW
				+ ((lnkRdReq & lnkRdGnt) ? (lnkRdSize[FIFO_AW+2:2]
					+ {{FIFO_AW{1'b0}}, (lnkRdSize[1:0] != 2'b00)}) : {(FIFO_AW+1){1'b0}})
				- {{FIFO_AW{1'b0}}, retPush};
		end
	end

	// Fill, then drain; reads stop for the whole drain phase
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			drain <= 1'b0;
		else if (!chanBusy | patMode)
			drain <= 1'b0;
		else if (drain)
			drain <= ~((level == {{FIFO_AW{1'b0}}, 1'b1}) & fifoPop); // [RULE10]
		else
			drain <= (rdOutW == {(FIFO_AW+1){1'b0}}) & ~lnkRdReq
				& ((level >= FILL_THRESH[FIFO_AW:0])
				| ((rdRem == 33'h0) & (level != {(FIFO_AW+1){1'b0}}))); // [RULE10]
	end

	// Pattern generator feeds staging concurrently with the writer
	assign genUnit = pat32 ? ((genRem < 33'd4) ? genRem[2:0] : 3'd4) : 3'd1; // [RULE14]
	assign genPush = chanBusy & patMode & (genRem != 33'h0) & fifoInReady;

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			genRem <= `DVC_RST_REM;
			patCur <= `DVC_RST_WORD;
		end else if (goHit) begin
			genRem <= goPat ? {(byteCount == 32'h0), byteCount} : 33'h0; // [RULE11]
			patCur <= patStart; // [RULE12]
		end else if (genPush) begin
			genRem <= genRem - {30'h0, genUnit};
			if (ctrl[`DVC_CTRL_PATINC]) begin // [RULE13]
				if (pat32)
					patCur <= patCur + 32'h0000_0001; // [RULE18]
				else
					patCur <= {patCur[31:8], patCur[7:0] + 8'h01}; // [RULE18]
			end
		end
	end

	assign retPush     = lnkRetValid & fifoInReady & ~patMode;
	assign lnkRetReady = fifoInReady;

	dvc_fifo #(
		.WIDTH (32),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) uStage (
		.core_clk (core_clk),
		.rstn     (rstn),
		.inValid  (patMode ? genPush : lnkRetValid), // [RULE7]
		.inReady  (fifoInReady),
		.inData   (patMode ? patCur : lnkRetData),
		.outValid (fifoOutValid),
		.outReady (fifoPop),
		.outData  (fifoOutData),
		.level    (level)
	);

	// Write sizing and trimming of the final unit
	assign wrUnit = (patMode & ~pat32) ? 3'd1
		: ((wrRem < 33'd4) ? wrRem[2:0] : 3'd4); // [RULE16]
	// Bytes stay in memory order; no swap toward PCI/X
	assign wrDataFmt = (patMode & ~pat32) ? {4{fifoOutData[7:0]}}
		: (patMode & ~dstPci & (wrUnit != 3'd4))
			? (fifoOutData >> {(3'd4 - wrUnit), 3'b000}) // [RULE17]
			: fifoOutData; // [RULE15]
	assign fifoPop = fifoOutValid & ~lnkWrReq & (wrRem != 33'h0)
		& (patMode | drain); // [RULE8] [RULE10]

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lnkWrReq  <= 1'b0;
			lnkWrAddr <= `DVC_RST_WORD;
			lnkWrData <= `DVC_RST_WORD;
			lnkWrSize <= 3'd0;
			lnkWrPci  <= 1'b0;
			wrRem     <= `DVC_RST_REM;
			chanBusy  <= 1'b0;
			done      <= 1'b0;
		end else begin
			if (goHit) begin
				wrRem     <= {(byteCount == 32'h0), byteCount}; // [RULE1]
				lnkWrAddr <= dstAddr; // [RULE11]
				lnkWrPci  <= goPci; // [RULE11]
				chanBusy  <= 1'b1;
				done      <= 1'b0;
			end else if (lnkWrReq & lnkWrGnt) begin
				lnkWrReq  <= 1'b0; // [RULE9]
				lnkWrAddr <= lnkWrAddr + {29'h0, lnkWrSize};
				wrRem     <= wrRem - {30'h0, lnkWrSize};
				if (wrRem == {30'h0, lnkWrSize}) begin
					chanBusy <= 1'b0; // [RULE19]
					done     <= 1'b1;
				end
			end else if (fifoPop) begin
				lnkWrReq  <= 1'b1; // [RULE8]
				lnkWrData <= wrDataFmt; // [RULE9]
				lnkWrSize <= wrUnit; // [RULE16]
			end
		end
	end
endmodule

// ===== dvc_dma_checker.sv
// Port assertions of the copy and pattern channel
module dvc_dma_checker #(
	parameter FIFO_DEPTH = 16
) (
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic        avWaitrequest,
	input wire logic        lnkRdReq,
	input wire logic        lnkRdGnt,
	input wire logic [31:0] lnkRdAddr,
	input wire logic [31:0] lnkRdSize,
	input wire logic        lnkRdQueue,
	input wire logic        lnkWrReq,
	input wire logic        lnkWrGnt,
	input wire logic [31:0] lnkWrData,
	input wire logic [2:0]  lnkWrSize,
	input wire logic        chanBusy
);
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	read_held_a:
		assert property (lnkRdReq && !lnkRdGnt |=> lnkRdReq && $stable(lnkRdAddr)
			&& $stable(lnkRdSize) && $stable(lnkRdQueue)) else $error("read request moved");
	queue_swap_a:
		assert property (lnkRdReq && lnkRdGnt |=> !lnkRdReq && lnkRdQueue != $past(lnkRdQueue))
			else $error("read queue not alternated");
	read_size_a:
		assert property (lnkRdReq |-> lnkRdSize != 0 && lnkRdSize <= 4 * FIFO_DEPTH)
			else $error("read size out of range");
	write_held_a:
		assert property (lnkWrReq && !lnkWrGnt |=> lnkWrReq && $stable(lnkWrData)
			&& $stable(lnkWrSize)) else $error("write request moved");
	write_size_a:
		assert property (lnkWrReq |-> lnkWrSize inside {[1:4]}) else $error("write size");
	fill_drain_a:
		assert property (!(lnkRdReq && lnkWrReq)) else $error("fill and drain together");
	idle_quiet_a:
		assert property (!chanBusy |-> !lnkRdReq && !lnkWrReq) else $error("request when idle");
	wait_pulse_a:
		assert property (!avWaitrequest |=> avWaitrequest) else $error("waitrequest low twice");
endmodule

// ===== dvc_link_model.sv
// Far side model: linkage arbiter, VME source slave and destination store
module dvc_link_model #(
	parameter SEED = 32'h0000_5a3c
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        lnkRdReq,
	output logic             lnkRdGnt,
	input  wire logic [31:0] lnkRdAddr,
	input  wire logic [31:0] lnkRdSize,
	output logic             lnkRetValid,
	input  wire logic        lnkRetReady,
	output logic      [31:0] lnkRetData,
	input  wire logic        lnkWrReq,
	output logic             lnkWrGnt,
	input  wire logic [31:0] lnkWrAddr,
	input  wire logic [31:0] lnkWrData,
	input  wire logic [2:0]  lnkWrSize
);
	logic [31:0] sd;
	logic [31:0] pend [$];
	logic [7:0]  mem [int];
	int          rdCount = 0;
	function automatic logic [31:0] srcWord(input logic [31:0] a);
		return {~a[15:0], a[15:0] ^ 16'h3c5a};
	endfunction
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sd <= SEED;
			lnkRdGnt <= 0;
			lnkWrGnt <= 0;
			lnkRetValid <= 0;
			lnkRetData <= 0;
			pend.delete();
		end else begin
			sd <= {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
			// Random grants, so requests wait a varying time
			lnkRdGnt <= lnkRdReq && !lnkRdGnt && sd[0];
			lnkWrGnt <= lnkWrReq && !lnkWrGnt && sd[1];
			if (lnkRdReq && lnkRdGnt) begin
				rdCount++;
				for (int i = 0; i < lnkRdSize; i += 4)
					pend.push_back(lnkRdAddr + i);
			end
			if (lnkWrReq && lnkWrGnt)
				for (int i = 0; i < lnkWrSize; i++)
					mem[lnkWrAddr + i] = lnkWrData[8*i+:8];
			if (lnkRetValid && lnkRetReady)
				void'(pend.pop_front());
			if (!lnkRetValid || lnkRetReady) begin
				lnkRetValid <= pend.size() != 0 && sd[3];
				// Idle data toggles so a stale word never passes for a fresh one
				lnkRetData <= (pend.size() != 0 && sd[3]) ? srcWord(pend[0]) : ~lnkRetData;
			end
		end
	end
endmodule

// ===== dvc_dma_tb.sv
// Self-checking bench of the copy and pattern channel
`include "dvc_dma_defs.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module dvc_dma_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 0;
	logic        rstn = 0;
	logic [4:0]  avAddress = 0;
	logic        avRead = 0;
	logic        avWrite = 0;
	logic [31:0] avWritedata = 0;
	logic [31:0] seed = 32'ha122;
	logic [31:0] rd;
	logic [31:0] r;
	logic        sawFull;
	int          num_errors = 0;
	int          num_checks = 0;
	int          t = 0;
	wire  [31:0] avReaddata, lnkRdAddr, lnkRdSize, lnkRetData, lnkWrAddr, lnkWrData;
	wire  [2:0]  lnkWrSize;
	wire         avWaitrequest, lnkRdReq, lnkRdGnt, lnkRetValid, lnkRetReady;
	wire         lnkWrReq, lnkWrGnt, lnkWrPci, chanBusy;
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk)
		if (chanBusy && lnkRetReady === 1'b0) sawFull <= 1;
	dvc_dma uut (.core_clk(core_clk), .rstn(rstn), .avAddress(avAddress), .avRead(avRead),
		.avWrite(avWrite), .avByteenable(4'hf), .avWritedata(avWritedata),
		.avReaddata(avReaddata), .avWaitrequest(avWaitrequest), .lnkRdReq(lnkRdReq),
		.lnkRdGnt(lnkRdGnt), .lnkRdAddr(lnkRdAddr), .lnkRdSize(lnkRdSize), .lnkRdQueue(),
		.lnkRetValid(lnkRetValid), .lnkRetReady(lnkRetReady), .lnkRetData(lnkRetData),
		.lnkWrReq(lnkWrReq), .lnkWrGnt(lnkWrGnt), .lnkWrAddr(lnkWrAddr),
		.lnkWrData(lnkWrData), .lnkWrSize(lnkWrSize), .lnkWrPci(lnkWrPci),
		.chanBusy(chanBusy));
	dvc_link_model lm (.core_clk(core_clk), .rstn(rstn), .lnkRdReq(lnkRdReq),
		.lnkRdGnt(lnkRdGnt), .lnkRdAddr(lnkRdAddr), .lnkRdSize(lnkRdSize),
		.lnkRetValid(lnkRetValid), .lnkRetReady(lnkRetReady), .lnkRetData(lnkRetData),
		.lnkWrReq(lnkWrReq), .lnkWrGnt(lnkWrGnt), .lnkWrAddr(lnkWrAddr),
		.lnkWrData(lnkWrData), .lnkWrSize(lnkWrSize));
	function logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avAddress <= a;
		avWritedata <= d;
		avWrite <= wr;
		avRead <= !wr;
		do @(posedge core_clk); while (avWaitrequest !== 1'b0);
		rd = avReaddata;
		avWrite <= 0;
		avRead <= 0;
	endtask
	function automatic logic [7:0] expB(input logic [4:0] c, input logic [31:0] b, input int i,
		input int n);
		logic [31:0] w;
		int          j;
		j = i % 4;
		if (!c[`DVC_CTRL_PATMODE])
			w = lm.srcWord(b + i - j);
		else if (!c[`DVC_CTRL_PAT32])
			return b[7:0] + (c[`DVC_CTRL_PATINC] ? i[7:0] : 8'h00);
		else begin
			w = b + (c[`DVC_CTRL_PATINC] ? (i - j) / 4 : 0);
			// A ragged last unit keeps its top bytes when going to VME
			if (!c[`DVC_CTRL_DSTPCI] && n - i + j < 4) j = j + 4 - (n - i + j);
		end
		return w[8*j+:8];
	endfunction
	task automatic run(input logic [4:0] c, input logic [31:0] b, dst, input int n, blk);
		int          r0;
		logic [31:0] a;
		logic [7:0]  e;
		logic [7:0]  g;
		r0 = lm.rdCount;
		lm.mem.delete();
		sawFull = 0;
		`CHK("idle", 1'b0, chanBusy)
		bus(1, `DVC_OFS_SRC, b);
		bus(1, `DVC_OFS_PATTERN, b);
		bus(1, `DVC_OFS_DST, dst);
		bus(1, `DVC_OFS_COUNT, n);
		bus(1, `DVC_OFS_BLKSIZE, blk);
		bus(1, `DVC_OFS_CTRL, c | 5'h01);
		bus(0, `DVC_OFS_STATUS, 0);
		if (n >= 64) `CHK("busy", 1'b1, rd[`DVC_STAT_BUSY])
		while (chanBusy !== 1'b0) @(posedge core_clk);
		for (int i = -1; i <= n; i++) begin
			a = dst + i;
			e = (i < 0 || i == n) ? 8'hxx : expB(c, b, i, n);
			g = lm.mem.exists(a) ? lm.mem[a] : 8'hxx;
			`CHK("byte", e, g)
		end
		bus(0, `DVC_OFS_REMAIN, 0);
		`CHK("remain", 32'h0, rd)
		bus(0, `DVC_OFS_STATUS, 0);
		`CHK("done", 1'b1, rd[`DVC_STAT_DONE])
		`CHK("reads", c[1], lm.rdCount == r0)
		`CHK("space", c[`DVC_CTRL_DSTPCI], lnkWrPci)
		t = t + 1;
		$display("test %0d done", t);
	endtask
	task end_sim();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		$display("watchdog expired");
		end_sim();
	end
	initial begin
		repeat (3) @(posedge core_clk);
		rstn <= 1;
		bus(0, `DVC_OFS_BLKSIZE, 0);
		`CHK("blksize", `DVC_RST_BLKSIZE, rd)
		bus(1, `DVC_OFS_STATUS, 32'hffff_ffff);
		bus(0, `DVC_OFS_STATUS, 0);
		`CHK("status", 32'h0, rd)
		bus(0, 5'h1e, 0);
		`CHK("unmapped", 32'h0, rd)
		run(5'h00, 32'h1000, 32'h8000, 1, 32'h20);
		// One block fills the whole staging buffer while drain stalls
		run(5'h00, 32'h1100, 32'h8100, 64, 32'h40);
		`CHK("full", 1'b1, sawFull)
		repeat (3) begin
			r = rnd();
			run(5'h00, 32'h2000 + {r[7:2], 2'b00}, 32'h9000 + {r[15:10], 2'b00},
				1 + r[22:16] % 80, r[0] ? 32'h20 : 32'h40);
		end
		for (int m = 0; m < 8; m++) begin
			r = rnd();
			run({m[2:0], 2'b10}, m[1] ? 32'hffff_fffe : 32'hf111_11fe, 32'h4002, 27, 32'h20);
			run({m[2:0], 2'b10}, r, 32'h5000 + r[9:0], 1 + r[15:10] % 40, 32'h20);
		end
		end_sim();
	end
endmodule
bind dvc_dma dvc_dma_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.core_clk(core_clk), .rstn(rstn),
	.avWaitrequest(avWaitrequest), .lnkRdReq(lnkRdReq), .lnkRdGnt(lnkRdGnt),
	.lnkRdAddr(lnkRdAddr), .lnkRdSize(lnkRdSize), .lnkRdQueue(lnkRdQueue),
	.lnkWrReq(lnkWrReq), .lnkWrGnt(lnkWrGnt), .lnkWrData(lnkWrData),
	.lnkWrSize(lnkWrSize), .chanBusy(chanBusy));
